// ---- verilog/bcq_top.sv ----
// Breakpoint and trace qualifier comparator block for the emulator analyzer
`timescale 1ns/1ps
module bcq_top
  import bcq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Target bus cycle
  input wire logic busValid,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busData,
  input wire logic [EXT_W-1:0] busExt,
  input wire logic busFetch,
  input wire logic busWrite,
  input wire logic busIo,
  // Target shape
  input wire logic hasIoSpace,
  input wire logic [2:0] addrDigits,
  input wire logic [2:0] dataDigits,
  // Modes
  input wire logic andMode,
  input wire logic analyzerEn,
  input wire logic eventTiming,
  input bcq_unit_t timerUnits,
  // Pattern set write
  input wire logic cfgWr,
  input wire logic [1:0] cfgIdx,
  input bcq_set_t cfgSet,
  // Actions and trace
  output logic haltReq,
  output logic snapReq,
  output logic traceTrig,
  output logic traceRec,
  // Status
  output logic [1:0] armedIdx,
  output logic [TMR_W-1:0] timerCount,
  output logic timerRunning
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bcq_set_t [3:0] cfg;
    logic [NUM_BP-1:0][CNT_W-1:0] repCnt;
    logic [1:0] armIdx;
    bcq_state_t st;
    logic [DLY_W-1:0] postCnt;
    logic pendHalt;
    logic haltReq;
    logic snapReq;
    logic traceTrig;
    logic traceRec;
    logic tmrStart;
    logic tmrStop;
  } bcq_top_t;

  bcq_top_t q;
  bcq_top_t d;
  logic [3:0] hit;
  logic [3:0] sat;
  logic [NUM_BP-1:0] en;
  logic [NUM_BP-1:0] newEn;
  logic [1:0] nxt;
  logic [1:0] fireIdx;
  logic fire;
  logic fireHalt;
  logic qualAllDc;
  bcq_set_t wrSet;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  bcq_bus_if busIf ();

  assign busIf.valid = busValid;
  assign busIf.addr = busAddr;
  assign busIf.data = busData;
  assign busIf.ext = busExt;
  assign busIf.fetch = busFetch;
  assign busIf.write = busWrite;
  assign busIf.io = busIo;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_set
      bcq_match u_match (
        .bus(busIf),
        .cfg(q.cfg[g]),
        .hasIoSpace(hasIoSpace),
        .addrDigits(addrDigits),
        .dataDigits(dataDigits),
        .hit(hit[g])
      ); // [RULE1]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.haltReq = 1'b0;
    d.snapReq = 1'b0;
    d.traceTrig = 1'b0;
    d.traceRec = 1'b0;
    d.tmrStart = 1'b0;
    d.tmrStop = 1'b0;
    sat = 4'h0;
    fire = 1'b0;
    fireIdx = 2'h0;
    nxt = ARM_NONE;
    en = {q.cfg[2].enable, q.cfg[1].enable, q.cfg[0].enable};
    qualAllDc = (q.cfg[QUAL_IDX].addrDc == 6'h3f) && (q.cfg[QUAL_IDX].dataDc == 4'hf)
      && (q.cfg[QUAL_IDX].extDc == 4'hf) && (q.cfg[QUAL_IDX].cls == SEL_X)
      && (q.cfg[QUAL_IDX].dir == SEL_X) && (q.cfg[QUAL_IDX].spc == SEL_X);

    // Repetition counting: only the armed breakpoint counts in chained mode
    for (int i = 0; i < NUM_BP; i++)
    begin
      if (hit[i] && q.cfg[i].enable && (!andMode || q.armIdx == 2'(i)))
      begin
        if (q.repCnt[i] + CNT_ONE >= q.cfg[i].count)
        begin
          sat[i] = 1'b1; // [RULE2]
          d.repCnt[i] = '0;
        end
        else
          d.repCnt[i] = q.repCnt[i] + CNT_ONE; // [RULE2]
      end
    end

    if (andMode)
    begin
      if (q.armIdx != ARM_NONE && sat[q.armIdx])
      begin
        nxt = bcqNextActive(en, q.armIdx + 2'h1);
        if (nxt == ARM_NONE)
        begin
          fire = 1'b1;
          fireIdx = q.armIdx;
          d.armIdx = bcqNextActive(en, 2'h0);
        end
        else
          d.armIdx = nxt;
      end
    end
    else
    begin
      for (int i = NUM_BP - 1; i >= 0; i--)
      begin
        if (sat[i])
        begin
          fire = 1'b1;
          fireIdx = 2'(i);
        end
      end
    end

    // Event timing turns every halt into a snapshot
    fireHalt = (q.cfg[fireIdx].action == ACT_HALT) && !eventTiming; // [RULE10] [RULE13]

    case (q.st)
      ST_IDLE:
      begin
        if (fire && analyzerEn)
        begin
          d.traceTrig = 1'b1; // [RULE16]
          d.st = ST_POST;
          d.postCnt = q.cfg[QUAL_IDX].count[DLY_W-1:0]; // [RULE11]
          d.pendHalt = fireHalt; // [RULE12]
          d.tmrStop = eventTiming && (fireIdx == 2'h2); // [RULE17]
        end
        else if (fire)
        begin
          d.haltReq = fireHalt;
          d.snapReq = !fireHalt;
        end
      end
      ST_POST:
      begin
        if (busValid)
        begin
          if (q.postCnt == DLY_ONE)
          begin
            d.st = ST_IDLE;
            d.haltReq = q.pendHalt; // [RULE12]
            d.snapReq = !q.pendHalt;
          end
          else
            d.postCnt = q.postCnt - DLY_ONE; // [RULE11]
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // Trace records qualified cycles, the trigger cycle and the post-trigger window
    d.traceRec = analyzerEn && busValid
      && (hit[QUAL_IDX] || q.st == ST_POST || fire); // [RULE11] [RULE14]

    // Timer only starts on breakpoint 1; breakpoint 0 never touches it
    d.tmrStart = eventTiming && hit[1] && q.cfg[1].enable; // [RULE17]

    // A write reloads the set with zero counts raised to 1 and the delay cut to its low 8 bits, and restarts all chains
    wrSet = cfgSet;
    if (cfgIdx == QUAL_IDX)
    begin
      wrSet.count = {7'h00, (cfgSet.count[DLY_W-1:0] == 8'h00) ? DLY_ONE
                            : cfgSet.count[DLY_W-1:0]}; // [RULE11]
    end
    else if (cfgSet.count == '0)
      wrSet.count = CNT_ONE; // [RULE2]
    newEn = en;
    if (cfgIdx != QUAL_IDX)
      newEn[cfgIdx] = cfgSet.enable;
    if (cfgWr)
    begin
      d.cfg[cfgIdx] = wrSet;
      d.repCnt = '0;
      d.armIdx = bcqNextActive(newEn, 2'h0);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q.cfg <= {SET_RESET, SET_RESET, SET_RESET, SET_RESET}; // [RULE5] [RULE6] [RULE8]
      q.repCnt <= '0;
      q.armIdx <= ARM_NONE;
      q.st <= ST_IDLE;
      q.postCnt <= DLY_ONE;
      q.pendHalt <= 1'b0;
      q.haltReq <= 1'b0;
      q.snapReq <= 1'b0;
      q.traceTrig <= 1'b0;
      q.traceRec <= 1'b0;
      q.tmrStart <= 1'b0;
      q.tmrStop <= 1'b0;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Event timer
  // ----------------------------------------------------------------
  bcq_timer u_timer (
    .clk(clk),
    .reset(reset),
    .start(q.tmrStart),
    .stop(q.tmrStop),
    .busTick(busValid),
    .units(timerUnits),
    .count(timerCount),
    .running(timerRunning)
  ); // [RULE18]

  assign haltReq = q.haltReq;
  assign snapReq = q.snapReq;
  assign traceTrig = q.traceTrig;
  assign traceRec = q.traceRec;
  assign armedIdx = q.armIdx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_lastTrace;
    q.st == ST_POST && busValid && q.postCnt == DLY_ONE;
  endsequence

  sequence s_deliver;
    q.st == ST_IDLE && (haltReq != snapReq);
  endsequence

  property p_post_end;
    s_lastTrace |=> s_deliver;
  endproperty
  a_post_end: assert property (p_post_end) else $error("post delay end missed"); // [RULE11]

  property p_delay_range;
    q.cfg[QUAL_IDX].count >= 15'h0001 && q.cfg[QUAL_IDX].count <= 15'h00ff;
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("delay out of range"); // [RULE11]

  property p_rep_bound;
    q.repCnt[0] < q.cfg[0].count && q.repCnt[1] < q.cfg[1].count
      && q.repCnt[2] < q.cfg[2].count;
  endproperty
  a_rep_bound: assert property (p_rep_bound) else $error("repeat count overrun"); // [RULE2]

  property p_trig;
    (q.st == ST_IDLE && fire && analyzerEn) |=> traceTrig && q.st == ST_POST
      && !haltReq && !snapReq;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken"); // [RULE16]

  property p_postpone;
    (q.st == ST_POST && !(busValid && q.postCnt == DLY_ONE)) |=> !haltReq && !snapReq;
  endproperty
  a_postpone: assert property (p_postpone) else $error("break not postponed"); // [RULE12]

  property p_evt_snap;
    (q.st == ST_IDLE && fire && eventTiming)
      |=> !haltReq ##0 (q.st != ST_POST || !q.pendHalt);
  endproperty
  a_evt_snap: assert property (p_evt_snap) else $error("halt in event timing"); // [RULE13]

  property p_all_dc;
    (analyzerEn && busValid && qualAllDc) |=> traceRec;
  endproperty
  a_all_dc: assert property (p_all_dc) else $error("cycle not recorded"); // [RULE14]

  property p_tmr_start;
    (eventTiming && hit[1] && q.cfg[1].enable && !cfgWr) |=> q.tmrStart ##1 timerRunning;
  endproperty
  a_tmr_start: assert property (p_tmr_start) else $error("timer not started"); // [RULE17]

  property p_arm;
    (andMode && q.armIdx != ARM_NONE) |-> q.cfg[q.armIdx].enable;
  endproperty
  a_arm: assert property (p_arm) else $error("armed set not enabled"); // [RULE1]

  property p_no_io;
    (!hasIoSpace && analyzerEn && busValid && q.cfg[QUAL_IDX].addrDc == 6'h3f
      && q.cfg[QUAL_IDX].dataDc == 4'hf && q.cfg[QUAL_IDX].extDc == 4'hf
      && q.cfg[QUAL_IDX].cls == SEL_X && q.cfg[QUAL_IDX].dir == SEL_X) |=> traceRec;
  endproperty
  a_no_io: assert property (p_no_io) else $error("space selector not ignored"); // [RULE9]

endmodule : bcq_top

// ---- verilog/bcq_pkg.sv ----
// Constants, types and helper functions of the bus-cycle breakpoint qualifier
// Functional notes
// RULE1: Four comparator sets 0..3; set 3 is the trace qualifier, not a breakpoint.
// RULE2: Each breakpoint needs 1 to 32767 matching occurrences before it takes effect.
// RULE3: Address pattern has six hex digits, each digit maskable as don't care.
// RULE4: Data pattern has four hex digits, each digit maskable as don't care.
// RULE5: Four external lines compared bitwise with masks; qualifier resets fully masked.
// RULE6: Class selector: instruction fetch only, data only, or both.
// RULE7: Direction selector: read only, write only, or both.
// RULE8: Space selector: memory only, I/O only, or both.
// RULE9: Space selector ignored when target has no separate I/O space.
// RULE10: Each breakpoint picks halt or snapshot as its action.
// RULE11: Qualifier post-trigger delay 1..255 bus cycles, default 1, traced after trigger.
// RULE12: With analyzer enabled, break action waits out the post-trigger delay.
// RULE13: In event-timing mode all breakpoints act as snapshots, never halt.
// RULE14: Qualifier left at all don't-care records every bus cycle.
// RULE15: Significant address and data digits follow target bus widths.
// RULE16: With analyzer enabled, any satisfied breakpoint or chain end triggers the trace.
// RULE17: Event timer starts on breakpoint 1 match, stops on breakpoint 2 trigger; the code only stops it when the analyzer is enabled.
// RULE18: Event timer is 24 bits, counting microseconds, 100 ns steps or bus cycles.
// RULE19: A set matches only when all unmasked fields agree in the same cycle.
package bcq_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_DIG = 6;
  localparam int DATA_DIG = 4;
  localparam int ADDR_W = 4 * ADDR_DIG;
  localparam int DATA_W = 4 * DATA_DIG;
  localparam int EXT_W = 4;
  localparam int CNT_W = 15;
  localparam int DLY_W = 8;
  localparam int TMR_W = 24;
  localparam int NUM_BP = 3;
  localparam logic [1:0] QUAL_IDX = 2'h3;
  localparam logic [1:0] ARM_NONE = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [DLY_W-1:0] DLY_ONE = 8'h01;
  localparam logic [DLY_W-1:0] DLY_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Timer step timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_NS = 100;
  localparam int MICRO_NS = 1000;
  localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;
  localparam int MICRO_CYC = MICRO_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // SEL_A is I/R/M, SEL_B is D/W/I for the class, direction and space selectors
  typedef enum logic [2:0] {SEL_X = 3'h1, SEL_A = 3'h2, SEL_B = 3'h4} bcq_sel_t;
  typedef enum logic [1:0] {ACT_HALT = 2'h1, ACT_SNAP = 2'h2} bcq_act_t;
  typedef enum logic [2:0] {UNIT_MICRO = 3'h1, UNIT_STEP = 3'h2, UNIT_BUS = 3'h4} bcq_unit_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_POST = 2'h2} bcq_state_t;

  // Count holds the repetition count, or the post-trigger delay for set 3
  typedef struct packed {
    logic enable;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_DIG-1:0] addrDc;
    logic [DATA_W-1:0] data;
    logic [DATA_DIG-1:0] dataDc;
    logic [EXT_W-1:0] ext;
    logic [EXT_W-1:0] extDc;
    bcq_sel_t cls;
    bcq_sel_t dir;
    bcq_sel_t spc;
    bcq_act_t action;
    logic [CNT_W-1:0] count;
  } bcq_set_t;

  localparam bcq_set_t SET_RESET = '{enable: 1'b0, addr: 24'h000000, addrDc: 6'h3f,
                                     data: 16'h0000, dataDc: 4'hf, ext: 4'h0,
                                     extDc: 4'hf, cls: SEL_X, dir: SEL_X, spc: SEL_X,
                                     action: ACT_HALT, count: CNT_ONE};

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Bit mask of nibbles that must compare: not don't care and inside the bus width
  function automatic logic [ADDR_W-1:0] bcqCareMask(input logic [ADDR_DIG-1:0] dc,
                                                    input logic [2:0] digits);
    logic [ADDR_W-1:0] m;
    m = '0;
    for (int k = 0; k < ADDR_DIG; k++)
      if (!dc[k] && 3'(k) < digits)
        m[4*k +: 4] = 4'hf;
    return m;
  endfunction : bcqCareMask

  function automatic logic bcqSelOk(input bcq_sel_t sel, input logic a, input logic b);
    return (sel == SEL_X) || (sel == SEL_A && a) || (sel == SEL_B && b);
  endfunction : bcqSelOk

  // Lowest enabled breakpoint at or above from, ARM_NONE when there is none
  function automatic logic [1:0] bcqNextActive(input logic [NUM_BP-1:0] en,
                                               input logic [1:0] from);
    logic [1:0] r;
    r = ARM_NONE;
    for (int k = NUM_BP - 1; k >= 0; k--)
      if (en[k] && 2'(k) >= from)
        r = 2'(k);
    return r;
  endfunction : bcqNextActive

endpackage : bcq_pkg

// ---- verilog/bcq_bus_if.sv ----
// Observed target bus cycle shared between the top and its comparators
`timescale 1ns/1ps
interface bcq_bus_if;
  import bcq_pkg::*;
  logic valid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [EXT_W-1:0] ext;
  logic fetch;
  logic write;
  logic io;
  modport src (output valid, addr, data, ext, fetch, write, io);
  modport sink (input valid, addr, data, ext, fetch, write, io);
endinterface : bcq_bus_if

// ---- verilog/bcq_match.sv ----
// One pattern comparator set: address, data, external lines and cycle type
`timescale 1ns/1ps
module bcq_match
  import bcq_pkg::*;
(
  // Observed cycle
  bcq_bus_if.sink bus,
  // Pattern and target shape
  input bcq_set_t cfg,
  input wire logic hasIoSpace,
  input wire logic [2:0] addrDigits,
  input wire logic [2:0] dataDigits,
  // Result
  output logic hit
);

  logic [ADDR_W-1:0] addrCare;
  logic [ADDR_W-1:0] dataCareWide;
  logic fieldsOk;

  always_comb
  begin
    addrCare = bcqCareMask(cfg.addrDc, addrDigits); // [RULE3] [RULE15]
    dataCareWide = bcqCareMask({2'h0, cfg.dataDc}, dataDigits); // [RULE4] [RULE15]
    fieldsOk = (((bus.addr ^ cfg.addr) & addrCare) == '0)
      && (((bus.data ^ cfg.data) & dataCareWide[DATA_W-1:0]) == '0)
      && (((bus.ext ^ cfg.ext) & ~cfg.extDc) == '0); // [RULE5]
    hit = bus.valid && fieldsOk // [RULE19]
      && bcqSelOk(cfg.cls, bus.fetch, !bus.fetch) // [RULE6]
      && bcqSelOk(cfg.dir, !bus.write, bus.write) // [RULE7]
      && (!hasIoSpace || bcqSelOk(cfg.spc, !bus.io, bus.io)); // [RULE8] [RULE9]
  end

endmodule : bcq_match

// ---- verilog/bcq_timer.sv ----
// 24-bit event timer with microsecond, 100 ns and bus-cycle units
`timescale 1ns/1ps
module bcq_timer
  import bcq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic busTick,
  input bcq_unit_t units,
  // Result
  output logic [TMR_W-1:0] count,
  output logic running
);

  typedef struct packed {
    logic running;
    logic [7:0] pre;
    logic [TMR_W-1:0] count;
  } bcq_tmr_t;

  bcq_tmr_t q;
  bcq_tmr_t d;
  logic tick;

  always_comb
  begin
    d = q;
    tick = 1'b0;
    case (units)
      UNIT_BUS: tick = busTick;
      UNIT_STEP: tick = (q.pre == 8'(STEP_CYC - 1));
      default: tick = (q.pre == 8'(MICRO_CYC - 1));
    endcase
    d.pre = (tick || !q.running) ? 8'h00 : q.pre + 8'h01;
    if (start)
    begin
      d.running = 1'b1;
      d.count = '0;
      d.pre = 8'h00;
    end
    else if (stop)
      d.running = 1'b0;
    else if (q.running && tick)
      d.count = q.count + 24'h000001; // [RULE18]
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign count = q.count;
  assign running = q.running;

  property p_tmr_step;
    @(posedge clk) disable iff (reset)
      (q.running && tick && !start && !stop) |=> (q.count == $past(q.count) + 24'h000001);
  endproperty
  a_tmr_step: assert property (p_tmr_step) else $error("timer missed a step"); // [RULE18]

endmodule : bcq_timer

// ---- sim/bcq_target_bus.sv ----
// Target processor bus model presenting one bus cycle per call
`timescale 1ns/1ps
module bcq_target_bus
  import bcq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus cycle
  output logic busValid,
  output logic [ADDR_W-1:0] busAddr,
  output logic [DATA_W-1:0] busData,
  output logic [EXT_W-1:0] busExt,
  output logic busFetch,
  output logic busWrite,
  output logic busIo
);
  initial
  begin
    busValid = 1'b0;
    busAddr = 24'hffffff;
    busData = 16'hffff;
    busExt = 4'hf;
    busFetch = 1'b0;
    busWrite = 1'b0;
    busIo = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------------
  // Address, data and external lines flip once the cycle ends, so a stale value can never pass for a match
  task automatic cycle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [EXT_W-1:0] e, input logic [2:0] fwi);
    @(posedge clk);
    busValid <= 1'b1;
    busAddr <= a;
    busData <= d;
    busExt <= e;
    busFetch <= fwi[2];
    busWrite <= fwi[1];
    busIo <= fwi[0];
    @(posedge clk);
    busValid <= 1'b0;
    busAddr <= ~a;
    busData <= ~d;
    busExt <= ~e;
  endtask : cycle
endmodule : bcq_target_bus

// ---- sim/bcq_top_test.sv ----
// Self-checking testbench of the bus-cycle breakpoint qualifier
`timescale 1ns/1ps
module bcq_top_test
  import bcq_pkg::*;
  ;
  logic clk, reset, busValid, busFetch, busWrite, busIo, hasIoSpace;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busData;
  logic [EXT_W-1:0] busExt;
  logic [2:0] addrDigits, dataDigits;
  logic andMode, analyzerEn, eventTiming, cfgWr;
  logic [1:0] cfgIdx, armedIdx;
  bcq_unit_t timerUnits;
  bcq_set_t cfgSet, s;
  logic haltReq, snapReq, traceTrig, traceRec, timerRunning;
  logic [TMR_W-1:0] timerCount, tc;
  bcq_sel_t sels[3] = '{SEL_X, SEL_A, SEL_B};
  int errCount = 0;
  int cmpCount = 0;
  int nH = 0;
  int nS = 0;
  int nT = 0;
  int nRec = 0;

  bcq_top u_bcq_top (.clk, .reset, .busValid, .busAddr, .busData, .busExt, .busFetch,
    .busWrite, .busIo, .hasIoSpace, .addrDigits, .dataDigits, .andMode, .analyzerEn,
    .eventTiming, .timerUnits, .cfgWr, .cfgIdx, .cfgSet, .haltReq, .snapReq, .traceTrig,
    .traceRec, .armedIdx, .timerCount, .timerRunning);
  bcq_target_bus u_bcq_target_bus (.clk, .busValid, .busAddr, .busData, .busExt,
    .busFetch, .busWrite, .busIo);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses are tallied away from the active edge
  always @(negedge clk)
  begin
    nH = nH + int'(haltReq === 1'b1);
    nS = nS + int'(snapReq === 1'b1);
    nT = nT + int'(traceTrig === 1'b1);
    nRec = nRec + int'(traceRec === 1'b1);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : closeOut

  task automatic check(input logic ok, input string msg);
    cmpCount++;
    if (ok !== 1'b1)
    begin
      errCount++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic zero();
    nH = 0;
    nS = 0;
    nT = 0;
    nRec = 0;
  endtask : zero

  // Ends just after an edge so outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wrSet(input logic [1:0] idx, input bcq_set_t v);
    @(posedge clk);
    cfgWr <= 1'b1;
    cfgIdx <= idx;
    cfgSet <= v;
    @(posedge clk);
    cfgWr <= 1'b0;
  endtask : wrSet

  task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic [3:0] e,
                     input logic [2:0] fwi);
    u_bcq_target_bus.cycle(a, d, e, fwi);
  endtask : cyc

  task automatic hitCase(input logic [23:0] a, input logic [15:0] d, input logic [3:0] e,
                         input logic [2:0] fwi, input int expH);
    zero();
    cyc(a, d, e, fwi);
    idle(3);
    check(nH == expH && nS == 0, "halt count");
  endtask : hitCase

  function automatic bcq_set_t bp(input logic [23:0] a, input logic [5:0] adc);
    bcq_set_t v;
    v = SET_RESET;
    v.enable = 1'b1;
    v.addr = a;
    v.addrDc = adc;
    return v;
  endfunction : bp

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tMasks();
    wrSet(2'h0, bp(24'h123456, 6'h21));
    hitCase(24'h12345a, 16'h0, 4'h0, 3'h0, 1);
    hitCase(24'h92345a, 16'h0, 4'h0, 3'h0, 1);
    hitCase(24'h12355a, 16'h0, 4'h0, 3'h0, 0);
    s = bp(24'h0000aa, 6'h00);
    s.data = 16'hbeef;
    s.dataDc = 4'h2;
    s.ext = 4'ha;
    s.extDc = 4'h1;
    wrSet(2'h0, s);
    hitCase(24'h0000aa, 16'hbe0f, 4'hb, 3'h0, 1);
    hitCase(24'h0000aa, 16'hbeee, 4'ha, 3'h0, 0);
    hitCase(24'h0000aa, 16'hbeef, 4'h2, 3'h0, 0);
    hitCase(24'h0000ab, 16'hbeef, 4'ha, 3'h0, 0);
  endtask : tMasks

  // Fetch selects on 1 for its first code, write and I/O on 0
  task automatic tSelectors();
    for (int f = 0; f < 3; f++)
      for (int k = 0; k < 3; k++)
        for (int b = 0; b < 2; b++)
        begin
          s = bp(24'h0, 6'h3f);
          s.cls = (f == 0) ? sels[k] : SEL_X;
          s.dir = (f == 1) ? sels[k] : SEL_X;
          s.spc = (f == 2) ? sels[k] : SEL_X;
          wrSet(2'h0, s);
          hitCase(24'h0, 16'h0, 4'h0, 3'(b << (2 - f)),
                  int'(k == 0 || ((k == 1) == (b == int'(f == 0)))));
        end
    @(posedge clk);
    hasIoSpace <= 1'b0;
    s = bp(24'h0, 6'h3f);
    s.spc = SEL_A;
    wrSet(2'h0, s);
    hitCase(24'h0, 16'h0, 4'h0, 3'h1, 1);
    @(posedge clk);
    hasIoSpace <= 1'b1;
  endtask : tSelectors

  task automatic tCountDigits();
    s = bp(24'h000010, 6'h00);
    s.count = 15'h0003;
    wrSet(2'h0, s);
    zero();
    repeat (2) cyc(24'h000010, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nH == 0, "early halt");
    hitCase(24'h000010, 16'h0, 4'h0, 3'h0, 1);
    s.count = 15'h0001;
    s.action = ACT_SNAP;
    wrSet(2'h0, s);
    zero();
    cyc(24'h000010, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nS == 1 && nH == 0, "snapshot action");
    @(posedge clk);
    addrDigits <= 3'h4;
    dataDigits <= 3'h2;
    s = bp(24'h001234, 6'h00);
    s.data = 16'h0034;
    s.dataDc = 4'h0;
    wrSet(2'h0, s);
    hitCase(24'hab1234, 16'h5634, 4'h0, 3'h0, 1);
    hitCase(24'hab1334, 16'h5634, 4'h0, 3'h0, 0);
    @(posedge clk);
    addrDigits <= 3'h6;
    dataDigits <= 3'h4;
  endtask : tCountDigits

  task automatic tAnalyzer();
    @(posedge clk);
    analyzerEn <= 1'b1;
    wrSet(2'h0, bp(24'h000777, 6'h00));
    s = SET_RESET;
    s.count = 15'h0002;
    wrSet(2'h3, s);
    zero();
    cyc(24'h000777, 16'h0, 4'h0, 3'h0);
    cyc(24'h000001, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nT == 1 && nH == 0, "trigger, halt held off");
    cyc(24'h000001, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nH == 1, "delayed halt");
    check(nRec == 3, "every cycle traced");
    wrSet(2'h0, SET_RESET);
    wrSet(2'h3, bp(24'h000050, 6'h00));
    zero();
    cyc(24'h000050, 16'h0, 4'h0, 3'h0);
    cyc(24'h000051, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nRec == 1 && nT == 0 && nH == 0, "qualifier only");
    s = SET_RESET;
    s.spc = SEL_B;
    @(posedge clk);
    hasIoSpace <= 1'b0;
    wrSet(2'h3, s);
    zero();
    cyc(24'h000050, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nRec == 1, "space ignored in trace");
    @(posedge clk);
    hasIoSpace <= 1'b1;
    wrSet(2'h3, SET_RESET);
  endtask : tAnalyzer

  task automatic tTimer();
    @(posedge clk);
    eventTiming <= 1'b1;
    andMode <= 1'b1;
    timerUnits <= UNIT_BUS;
    wrSet(2'h1, bp(24'h000001, 6'h00));
    wrSet(2'h2, bp(24'h000002, 6'h00));
    idle(1);
    check(armedIdx === 2'h1, "first armed");
    zero();
    cyc(24'h000001, 16'h0, 4'h0, 3'h0);
    for (int k = 0; k < 4 && timerRunning !== 1'b1; k++)
      @(negedge clk);
    if (timerRunning !== 1'b1)
    begin
      check(1'b0, "timer never started");
      closeOut();
    end
    check(armedIdx === 2'h2, "chain advanced");
    repeat (3) cyc(24'h000000, 16'h0, 4'h0, 3'h0);
    cyc(24'h000002, 16'h0, 4'h0, 3'h0);
    idle(3);
    tc = timerCount;
    check(nT == 1 && timerRunning === 1'b0, "timer stop");
    check(tc >= 24'h000003 && tc <= 24'h000005, "bus cycle count");
    cyc(24'h000000, 16'h0, 4'h0, 3'h0);
    idle(3);
    check(nS == 1 && nH == 0, "halt forced to snapshot");
    check(timerCount === tc, "timer held");
    @(posedge clk);
    eventTiming <= 1'b0;
  endtask : tTimer

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    hasIoSpace = 1'b1;
    addrDigits = 3'h6;
    dataDigits = 3'h4;
    andMode = 1'b0;
    analyzerEn = 1'b0;
    eventTiming = 1'b0;
    timerUnits = UNIT_MICRO;
    cfgWr = 1'b0;
    cfgIdx = 2'h0;
    cfgSet = SET_RESET;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    idle(1);
    check(armedIdx === ARM_NONE && timerCount === '0 && haltReq === 1'b0, "reset");
    tMasks();
    tSelectors();
    tCountDigits();
    tAnalyzer();
    tTimer();
    closeOut();
  end
endmodule : bcq_top_test
